// File: hw/lmx_defs.vh
// Purpose: Shared constants for the logic, move and stack execution unit
// Assumes: Included by hw/lmx_exec.v and by the checker and testbench in sim
// Notes:   Encodings of operation selects are local to this block
`ifndef LMX_DEFS_VH
`define LMX_DEFS_VH

// Operation selects
`define LMX_OP_NOP        5'h00
`define LMX_OP_SRA_B      5'h01
`define LMX_OP_SRA_W      5'h02
`define LMX_OP_SRL_B      5'h03
`define LMX_OP_SRL_W      5'h04
`define LMX_OP_SWAP       5'h05
`define LMX_OP_MOVSX      5'h06
`define LMX_OP_MOVZX      5'h07
`define LMX_OP_MOVHI      5'h08
`define LMX_OP_LDD_ZX     5'h09
`define LMX_OP_LDD_OX     5'h0A
`define LMX_OP_CODE_DP    5'h0B
`define LMX_OP_CODE_PC    5'h0C
`define LMX_OP_EXT_RD16   5'h0D
`define LMX_OP_EXT_RD8    5'h0E
`define LMX_OP_EXCHANGE_DIGIT_OP       5'h0F
`define LMX_OP_PUSH_W     5'h10
`define LMX_OP_PUSH_D     5'h11
`define LMX_OP_POP_W      5'h12
`define LMX_OP_POP_D      5'h13
`define LMX_OP_LD_DISP    5'h14
`define LMX_OP_ST_DIR_D   5'h15
`define LMX_OP_LD_DATA_POINTER    5'h16
`define LMX_OP_MOV_B      5'h17
`define LMX_OP_MOV_W      5'h18
`define LMX_OP_MOV_D      5'h19
`define LMX_OP_AND        5'h1A
`define LMX_OP_OR         5'h1B
`define LMX_OP_XOR        5'h1C

// Port penalty classes
`define LMX_PEN_NONE      2'h0
`define LMX_PEN_ONE       2'h1
`define LMX_PEN_TWO       2'h2

// Direct addresses of the four I/O port registers (upper bits of a port address)
`define LMX_PORT_HI       6'h20
`define LMX_PORT_HI_RANGE 7:2

// Reset value of the extended data pointer low byte
`define LMX_XDPL_RST      8'h01

// Bit positions
`define LMX_B_MSB         7
`define LMX_W_MSB         15

// Executor states
`define LMX_ST_IDLE       1'h0
`define LMX_ST_BUSY       1'h1

`endif

// File: hw/lmx_exec.v
// Purpose: Execution and state timing for logical, shift, move, exchange and stack ops
// Assumes: Operand fetch done outside; one request at a time, taken only when ready
// Notes:   One sys_clk cycle stands for one state; results register when the request is taken, in the same cycle as done for one-state ops
//
// What this block does
// - Arithmetic right shift keeps the sign bit; 2 states compat, 1 native.
// - Logical right shift fills zero; 3 bytes/2 states compat, 2 bytes/1 native.
// - Nibble swap of accumulator, one byte, 2 states in both modes.
// - One-state-penalty ops add one state when addressing ports 0 to 3.
// - Two-state-penalty ops add two states when addressing a port.
// - Compat external moves use extended pointer low byte region, reset 01h.
// - Sign-extending move byte to word; 2 states compat, 1 native.
// - Zero-extending move byte to word clears upper byte; same timing.
// - Upper-half move loads high word, keeps low; 3 compat, 2 native.
// - Doubleword load of 16-bit data zero- or one-extends; 5 compat, 4 native.
// - Code byte read at accumulator plus pointer or pc; 6 states both.
// - External read: 16-bit pointer 5 states; 8-bit address 4 compat, 5 native.
// - Digit exchange swaps low nibbles with indirect RAM; 4 compat, 5 native.
// - Displaced indirect word load: 5 bytes/8 states compat, 4 bytes/7 native.
// - Doubleword store to direct address: 7 compat, 6 native.
// - Data pointer load with 16-bit constant: 3 bytes, 2 states both modes.
// - Doubleword reg moves 3/2 states; byte and word moves 2/1.
`include "lmx_defs.vh"
`timescale 1ns/10ps
`default_nettype none

module lmx_exec #(
  parameter DW = 32
) (
  // Clock and reset
  input  wire          sys_clk,
  input  wire          srst,
  // Configuration, sampled while srst is high
  input  wire          native_mode_cfg,
  // Request
  input  wire          req_valid,
  input  wire [4:0]    req_op,
  input  wire [1:0]    req_penalty,
  input  wire [7:0]    req_dir_addr,
  input  wire [DW-1:0] req_dst,
  input  wire [DW-1:0] req_src,
  input  wire [7:0]    req_acc,
  input  wire [7:0]    req_ram,
  input  wire [15:0]   req_ptr,
  input  wire [15:0]   req_pc,
  input  wire [15:0]   req_sp,
  input  wire [7:0]    req_xdpl_wr,
  input  wire          req_xdpl_we,
  // Status
  output reg           ready_q,
  output reg           done_q,
  output reg  [3:0]    len_q,
  output reg  [3:0]    states_q,
  output reg           native_q,
  // Results
  output reg  [DW-1:0] res_dst_q,
  output reg  [DW-1:0] res_src_q,
  output reg  [7:0]    res_acc_q,
  output reg  [7:0]    res_ram_q,
  output reg  [15:0]   sp_q,
  // Memory address of the operation
  output reg  [23:0]   mem_addr_q,
  output reg  [7:0]    ext_data_pointer_low_q
);

  reg          st_q;
  reg  [3:0]   cnt_q;
  reg  [3:0]   base_d;
  reg  [3:0]   len_d;
  reg  [3:0]   tot_d;
  reg  [DW-1:0] dst_d;
  reg  [7:0]   acc_d;
  reg  [7:0]   ram_d;
  reg  [15:0]  sp_d;
  reg  [23:0]  addr_d;
  wire         port_hit;

  // Two counts per op: compat first, native second
  function [3:0] pick;
    input       nat;
    input [3:0] c;
    input [3:0] n;
    begin
      pick = nat ? n : c;
    end
  endfunction

  assign port_hit = (req_dir_addr[`LMX_PORT_HI_RANGE] == `LMX_PORT_HI);

  // Length and base state count per opcode map
  always @* begin
    base_d = 4'h1;
    len_d  = 4'h1;
    case (req_op)
      `LMX_OP_SRA_B, `LMX_OP_SRA_W: begin
        base_d = pick(native_q, 4'h2, 4'h1);
        len_d  = pick(native_q, 4'h3, 4'h2);
      end
      `LMX_OP_SRL_B, `LMX_OP_SRL_W: begin
        base_d = pick(native_q, 4'h2, 4'h1);
        len_d  = pick(native_q, 4'h3, 4'h2);
      end
      `LMX_OP_SWAP: begin
        base_d = 4'h2;
        len_d  = 4'h1;
      end
      `LMX_OP_MOVSX, `LMX_OP_MOVZX: begin
        base_d = pick(native_q, 4'h2, 4'h1);
        len_d  = pick(native_q, 4'h3, 4'h2);
      end
      `LMX_OP_MOVHI: begin
        base_d = pick(native_q, 4'h3, 4'h2);
        len_d  = pick(native_q, 4'h5, 4'h4);
      end
      `LMX_OP_LDD_ZX, `LMX_OP_LDD_OX: begin
        base_d = pick(native_q, 4'h5, 4'h4);
        len_d  = pick(native_q, 4'h5, 4'h4);
      end
      `LMX_OP_CODE_DP, `LMX_OP_CODE_PC: begin
        base_d = 4'h6;
        len_d  = 4'h1;
      end
      `LMX_OP_EXT_RD16: begin
        base_d = 4'h5;
        len_d  = 4'h1;
      end
      `LMX_OP_EXT_RD8: begin
        base_d = pick(native_q, 4'h4, 4'h5);
        len_d  = pick(native_q, 4'h1, 4'h2);
      end
      `LMX_OP_EXCHANGE_DIGIT_OP: begin
        base_d = pick(native_q, 4'h4, 4'h5);
        len_d  = pick(native_q, 4'h1, 4'h2);
      end
      `LMX_OP_PUSH_W: begin
        base_d = pick(native_q, 4'h6, 4'h5);
        len_d  = pick(native_q, 4'h3, 4'h2);
      end
      `LMX_OP_PUSH_D: begin
        base_d = pick(native_q, 4'hA, 4'h9);
        len_d  = pick(native_q, 4'h3, 4'h2);
      end
      `LMX_OP_POP_W: begin
        base_d = pick(native_q, 4'h5, 4'h4);
        len_d  = pick(native_q, 4'h3, 4'h2);
      end
      `LMX_OP_POP_D: begin
        base_d = pick(native_q, 4'h9, 4'h8);
        len_d  = pick(native_q, 4'h3, 4'h2);
      end
      `LMX_OP_LD_DISP: begin
        base_d = pick(native_q, 4'h8, 4'h7);
        len_d  = pick(native_q, 4'h5, 4'h4);
      end
      `LMX_OP_ST_DIR_D: begin
        base_d = pick(native_q, 4'h7, 4'h6);
        len_d  = pick(native_q, 4'h4, 4'h3);
      end
      `LMX_OP_LD_DATA_POINTER: begin
        base_d = 4'h2;
        len_d  = 4'h3;
      end
      `LMX_OP_MOV_B, `LMX_OP_MOV_W: begin
        base_d = pick(native_q, 4'h2, 4'h1);
        len_d  = pick(native_q, 4'h3, 4'h2);
      end
      `LMX_OP_MOV_D: begin
        base_d = pick(native_q, 4'h3, 4'h2);
        len_d  = pick(native_q, 4'h3, 4'h2);
      end
      `LMX_OP_AND, `LMX_OP_OR, `LMX_OP_XOR: begin
        base_d = pick(native_q, 4'h2, 4'h1);
        len_d  = pick(native_q, 4'h3, 4'h2);
      end
      default: begin
        base_d = 4'h1;
        len_d  = 4'h1;
      end
    endcase
    tot_d = base_d;
    if (port_hit && (req_penalty == `LMX_PEN_ONE)) begin
      tot_d = base_d + 4'h1;
    end else if (port_hit && (req_penalty == `LMX_PEN_TWO)) begin
      tot_d = base_d + 4'h2;
    end
  end

  // Data path
  always @* begin
    dst_d  = req_dst;
    acc_d  = req_acc;
    ram_d  = req_ram;
    sp_d   = sp_q;
    addr_d = 24'h000000;
    case (req_op)
      `LMX_OP_SRA_B:
        dst_d = {req_dst[DW-1:8], req_dst[`LMX_B_MSB], req_dst[7:1]};
      `LMX_OP_SRA_W:
        dst_d = {req_dst[DW-1:16], req_dst[`LMX_W_MSB], req_dst[15:1]};
      `LMX_OP_SRL_B:
        dst_d = {req_dst[DW-1:8], 1'b0, req_dst[7:1]};
      `LMX_OP_SRL_W:
        dst_d = {req_dst[DW-1:16], 1'b0, req_dst[15:1]};
      `LMX_OP_SWAP:
        acc_d = {req_acc[3:0], req_acc[7:4]};
      `LMX_OP_MOVSX:
        dst_d = {req_dst[DW-1:16], {8{req_src[`LMX_B_MSB]}}, req_src[7:0]};
      `LMX_OP_MOVZX:
        dst_d = {req_dst[DW-1:16], 8'h00, req_src[7:0]};
      `LMX_OP_MOVHI:
        dst_d = {req_src[15:0], req_dst[15:0]};
      `LMX_OP_LDD_ZX:
        dst_d = {16'h0000, req_src[15:0]};
      `LMX_OP_LDD_OX:
        dst_d = {16'hFFFF, req_src[15:0]};
      `LMX_OP_CODE_DP: begin
        addr_d = {8'h00, req_ptr + {8'h00, req_acc}};
        acc_d  = req_ram;
      end
      `LMX_OP_CODE_PC: begin
        addr_d = {8'h00, req_pc + {8'h00, req_acc}};
        acc_d  = req_ram;
      end
      `LMX_OP_EXT_RD16: begin
        addr_d = {ext_data_pointer_low_q, req_ptr};
        acc_d  = req_ram;
      end
      `LMX_OP_EXT_RD8: begin
        addr_d = {ext_data_pointer_low_q, 8'h00, req_dir_addr};
        acc_d  = req_ram;
      end
      `LMX_OP_EXCHANGE_DIGIT_OP: begin
        acc_d  = {req_acc[7:4], req_ram[3:0]};
        ram_d  = {req_ram[7:4], req_acc[3:0]};
        addr_d = {16'h0000, req_dir_addr};
      end
      `LMX_OP_PUSH_W: begin
        sp_d   = sp_q + 16'h0002;
        addr_d = {8'h00, sp_q + 16'h0001};
      end
      `LMX_OP_PUSH_D: begin
        sp_d   = sp_q + 16'h0004;
        addr_d = {8'h00, sp_q + 16'h0001};
      end
      `LMX_OP_POP_W: begin
        addr_d = {8'h00, sp_q - 16'h0001};
        dst_d  = {req_dst[DW-1:16], req_src[15:0]};
        sp_d   = sp_q - 16'h0002;
      end
      `LMX_OP_POP_D: begin
        addr_d = {8'h00, sp_q - 16'h0003};
        dst_d  = req_src;
        sp_d   = sp_q - 16'h0004;
      end
      `LMX_OP_LD_DISP: begin
        addr_d = req_src[23:0] + {8'h00, req_ptr};
        dst_d  = {req_dst[DW-1:16], req_ram, req_acc};
      end
      `LMX_OP_ST_DIR_D:
        addr_d = {16'h0000, req_dir_addr};
      `LMX_OP_LD_DATA_POINTER:
        dst_d  = {req_dst[DW-1:16], req_ptr};
      `LMX_OP_MOV_B:
        dst_d  = {req_dst[DW-1:8], req_src[7:0]};
      `LMX_OP_MOV_W:
        dst_d  = {req_dst[DW-1:16], req_src[15:0]};
      `LMX_OP_MOV_D:
        dst_d  = req_src;
      `LMX_OP_AND:
        dst_d  = req_dst & req_src;
      `LMX_OP_OR:
        dst_d  = req_dst | req_src;
      `LMX_OP_XOR:
        dst_d  = req_dst ^ req_src;
      default:
        dst_d  = req_dst;
    endcase
  end

  // Sequencer: request taken when idle, done pulses after the state count
  always @(posedge sys_clk) begin
    if (srst) begin
      st_q      <= `LMX_ST_IDLE;
      cnt_q     <= 4'h0;
      ready_q   <= 1'b0;
      done_q    <= 1'b0;
      len_q     <= 4'h0;
      states_q  <= 4'h0;
      native_q  <= native_mode_cfg;
      res_dst_q <= {DW{1'b0}};
      res_src_q <= {DW{1'b0}};
      res_acc_q <= 8'h00;
      res_ram_q <= 8'h00;
      sp_q      <= req_sp;
      mem_addr_q <= 24'h000000;
      ext_data_pointer_low_q <= `LMX_XDPL_RST;
    end else begin
      done_q <= 1'b0;
      if (req_xdpl_we) begin
        ext_data_pointer_low_q <= req_xdpl_wr;
      end
      case (st_q)
        `LMX_ST_IDLE: begin
          ready_q <= 1'b1;
          if (req_valid && ready_q) begin
            ready_q    <= 1'b0;
            len_q      <= len_d;
            states_q   <= tot_d;
            res_dst_q  <= dst_d;
            res_src_q  <= req_src;
            res_acc_q  <= acc_d;
            res_ram_q  <= ram_d;
            sp_q       <= sp_d;
            mem_addr_q <= addr_d;
            if (tot_d == 4'h1) begin
              done_q <= 1'b1;
              ready_q <= 1'b1;
            end else begin
              cnt_q <= tot_d - 4'h2;
              st_q  <= `LMX_ST_BUSY;
            end
          end
        end
        `LMX_ST_BUSY: begin
          if (cnt_q == 4'h0) begin
            done_q  <= 1'b1;
            ready_q <= 1'b1;
            st_q    <= `LMX_ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: st_q <= `LMX_ST_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

// File: sim/lmx_mem_model.sv
// Purpose: Program memory and external data memory stand-in
// Assumes: Combinational read at any address, no wait states
// Notes:   Content is a fixed scramble of the address
`timescale 1ns/10ps
`default_nettype none
module lmx_mem_model (
  // Read port
  input  wire logic [23:0] addr,
  output logic      [7:0]  rd_data
);
  assign rd_data = addr[7:0] ^ addr[15:8] ^ addr[23:16] ^ 8'hA5;
endmodule
`default_nettype wire

// File: sim/lmx_exec_checker.sv
// Purpose: Port-level assertions for the logic, move and stack executor
// Assumes: Single clock domain, synchronous active-high reset
// Notes:   Bound into every lmx_exec instance
`include "lmx_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module lmx_exec_checker #(
  parameter DW = 32
) (
  // Clock and reset
  input wire logic          sys_clk,
  input wire logic          srst,
  // Request
  input wire logic          req_valid,
  input wire logic [4:0]    req_op,
  input wire logic [1:0]    req_penalty,
  input wire logic [DW-1:0] req_dst,
  input wire logic [7:0]    req_acc,
  input wire logic [7:0]    req_ram,
  // Status and results
  input wire logic          ready_q,
  input wire logic          done_q,
  input wire logic [3:0]    len_q,
  input wire logic [3:0]    states_q,
  input wire logic [DW-1:0] res_dst_q,
  input wire logic [7:0]    res_acc_q,
  input wire logic [15:0]   sp_q,
  input wire logic [7:0]    ext_data_pointer_low_q
);
  logic       take;
  logic [3:0] cnt_q;
  assign take = req_valid && ready_q;
  // Cycles since the last taken request
  always @(posedge sys_clk) begin
    if (srst || take) cnt_q <= 4'h1;
    else if (cnt_q != 4'hF) cnt_q <= cnt_q + 4'h1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  a_ready_after_reset: assert property ($fell(srst) |-> !ready_q ##1 ready_q)
    else $error("ready not raised one cycle after reset");
  a_xdpl_reset_val: assert property ($fell(srst) |-> ext_data_pointer_low_q == 8'h01)
    else $error("pointer low byte not 01 after reset");
  a_done_at_count: assert property (done_q |-> cnt_q == states_q)
    else $error("done not at the reported state count");
  a_swap_timing: assert property (take && req_op == `LMX_OP_SWAP |=>
    len_q == 4'h1 && states_q == 4'h2 && !done_q ##1 done_q) else $error("swap timing wrong");
  a_sra_sign: assert property (take && req_op == `LMX_OP_SRA_B |=>
    res_dst_q[7:0] == {$past(req_dst[7]), $past(req_dst[7:1])}) else $error("sra lost sign");
  a_srl_zero: assert property (take && req_op == `LMX_OP_SRL_W |=>
    res_dst_q[15:0] == {1'b0, $past(req_dst[15:1])}) else $error("srl fill wrong");
  a_exchange_digit_op_nibbles: assert property (take && req_op == `LMX_OP_EXCHANGE_DIGIT_OP |=>
    res_acc_q == {$past(req_acc[7:4]), $past(req_ram[3:0])}) else $error("digit swap wrong");
  a_push_sp_step: assert property (take && req_op == `LMX_OP_PUSH_W |=>
    sp_q == $past(sp_q) + 16'h2) else $error("word push stack step wrong");
  c_push_dword: cover property (take && req_op == `LMX_OP_PUSH_D);
  c_pen_two: cover property (take && req_penalty == `LMX_PEN_TWO);
  c_long_done: cover property (done_q && states_q > 4'h8);
endmodule
bind lmx_exec lmx_exec_checker #(.DW(DW)) u_chk (
  .sys_clk(sys_clk), .srst(srst), .req_valid(req_valid), .req_op(req_op),
  .req_penalty(req_penalty), .req_dst(req_dst), .req_acc(req_acc), .req_ram(req_ram),
  .ready_q(ready_q), .done_q(done_q), .len_q(len_q), .states_q(states_q),
  .res_dst_q(res_dst_q), .res_acc_q(res_acc_q), .sp_q(sp_q),
  .ext_data_pointer_low_q(ext_data_pointer_low_q));
`default_nettype wire

// File: sim/testbench.sv
// Purpose: Self-checking bench for the logic, move and stack executor
// Assumes: One state per sys_clk cycle; opcode map chosen at reset
// Notes:   Every op but NOP in both maps, port penalties, pointer write, random mix
`include "lmx_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        sys_clk = 1'b0, srst = 1'b1, nat = 1'b0, req_valid = 1'b0, xd_we = 1'b0;
  logic [4:0]  req_op = 5'h00, rop;
  logic [1:0]  pen = 2'h0, pen_r;
  logic [7:0]  dir = 8'h00, acc = 8'h00, xd_wr = 8'h00, xd_m = 8'h01;
  logic [15:0] ptr = 16'h0000, pc = 16'h0000, sp_in = 16'h0100, sp_m, sz;
  logic [31:0] dst = 32'h0, src = 32'h0, rdst, rsrc;
  logic [23:0] m_addr, maddr;
  logic        ready, done, natq;
  logic [3:0]  len, st;
  logic [7:0]  racc, rram, xdpl, mem_data;
  logic [15:0] spq;
  int          n_errors = 0, n_compared = 0, cyc = 0;

  always #20 sys_clk = ~sys_clk;

  assign m_addr = req_op == `LMX_OP_CODE_DP ? {8'h00, ptr + {8'h00, acc}} :
                  req_op == `LMX_OP_CODE_PC ? {8'h00, pc + {8'h00, acc}} :
                  req_op == `LMX_OP_EXT_RD16 ? {xd_m, ptr} : {xd_m, 8'h00, dir};
  lmx_mem_model mem (.addr(m_addr), .rd_data(mem_data));
  lmx_exec #(.DW(32)) dut (
    .sys_clk(sys_clk), .srst(srst), .native_mode_cfg(nat), .req_valid(req_valid),
    .req_op(req_op), .req_penalty(pen), .req_dir_addr(dir), .req_dst(dst), .req_src(src),
    .req_acc(acc), .req_ram(mem_data), .req_ptr(ptr), .req_pc(pc), .req_sp(sp_in),
    .req_xdpl_wr(xd_wr), .req_xdpl_we(xd_we), .ready_q(ready), .done_q(done), .len_q(len),
    .states_q(st), .native_q(natq), .res_dst_q(rdst), .res_src_q(rsrc), .res_acc_q(racc),
    .res_ram_q(rram), .sp_q(spq), .mem_addr_q(maddr), .ext_data_pointer_low_q(xdpl));

  task automatic wrap_up;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Bytes and states as {len compat, states compat, len native, states native}
  function automatic logic [15:0] tbl(input logic [4:0] op);
    case (op)
      `LMX_OP_SWAP: tbl = 16'h1212;
      `LMX_OP_MOVHI: tbl = 16'h5342;
      `LMX_OP_LDD_ZX, `LMX_OP_LDD_OX: tbl = 16'h5544;
      `LMX_OP_CODE_DP, `LMX_OP_CODE_PC: tbl = 16'h1616;
      `LMX_OP_EXT_RD16: tbl = 16'h1515;
      `LMX_OP_EXT_RD8, `LMX_OP_EXCHANGE_DIGIT_OP: tbl = 16'h1425;
      `LMX_OP_PUSH_W: tbl = 16'h3625;
      `LMX_OP_PUSH_D: tbl = 16'h3A29;
      `LMX_OP_POP_W: tbl = 16'h3524;
      `LMX_OP_POP_D: tbl = 16'h3928;
      `LMX_OP_LD_DISP: tbl = 16'h5847;
      `LMX_OP_ST_DIR_D: tbl = 16'h4736;
      `LMX_OP_LD_DATA_POINTER: tbl = 16'h3232;
      `LMX_OP_MOV_D: tbl = 16'h3322;
      default: tbl = 16'h3221;
    endcase
  endfunction

  task automatic run(input logic [4:0] op, input logic [1:0] p, input logic [7:0] d);
    logic [15:0] t;
    logic [3:0]  es;
    int          k;
    t = tbl(op);
    es = nat ? t[3:0] : t[11:8];
    if (d[7:2] == 6'h20 && p == `LMX_PEN_ONE) es = es + 4'h1;
    if (d[7:2] == 6'h20 && p == `LMX_PEN_TWO) es = es + 4'h2;
    k = 0;
    while (ready !== 1'b1 && k < 30) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    @(posedge sys_clk);
    {req_valid, req_op, pen, dir} <= {1'b1, op, p, d};
    {dst, src, acc} <= {$urandom, $urandom, 8'($urandom)};
    {ptr, pc} <= $urandom & 32'h7FFF7FFF;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    #1;
    chk({len, st, ready}, {nat ? t[7:4] : t[15:12], es, es == 4'h1});
    sz = (op == `LMX_OP_PUSH_W || op == `LMX_OP_POP_W) ? 16'h2 : 16'h4;
    case (op)
      `LMX_OP_SRA_B: chk(rdst[7:0], {dst[7], dst[7:1]});
      `LMX_OP_SRA_W: chk(rdst[15:0], {dst[15], dst[15:1]});
      `LMX_OP_SRL_B: chk(rdst[7:0], {1'b0, dst[7:1]});
      `LMX_OP_SRL_W: chk(rdst[15:0], {1'b0, dst[15:1]});
      `LMX_OP_SWAP: chk(racc, {acc[3:0], acc[7:4]});
      `LMX_OP_MOVSX: chk(rdst[15:0], {{8{src[7]}}, src[7:0]});
      `LMX_OP_MOVZX: chk(rdst[15:0], {8'h00, src[7:0]});
      `LMX_OP_MOVHI: chk(rdst, {src[15:0], dst[15:0]});
      `LMX_OP_LDD_ZX: chk(rdst, {16'h0000, src[15:0]});
      `LMX_OP_LDD_OX: chk(rdst, {16'hFFFF, src[15:0]});
      `LMX_OP_CODE_DP, `LMX_OP_CODE_PC, `LMX_OP_EXT_RD8, `LMX_OP_EXT_RD16:
        chk({maddr, racc}, {m_addr, mem_data});
      `LMX_OP_EXCHANGE_DIGIT_OP:
        chk({racc, rram}, {acc[7:4], mem_data[3:0], mem_data[7:4], acc[3:0]});
      `LMX_OP_PUSH_W, `LMX_OP_PUSH_D: begin
        chk({spq, maddr[15:0]}, {sp_m + sz, sp_m + 16'h1});
        sp_m = sp_m + sz;
      end
      `LMX_OP_POP_W, `LMX_OP_POP_D: begin
        chk({spq, maddr[15:0]}, {sp_m - sz, sp_m - sz + 16'h1});
        sp_m = sp_m - sz;
      end
      `LMX_OP_LD_DISP: begin
        chk(maddr, src[23:0] + {8'h00, ptr});
        chk(rdst[15:0], {mem_data, acc});
      end
      `LMX_OP_ST_DIR_D: chk(maddr, {16'h0000, dir});
      `LMX_OP_LD_DATA_POINTER: chk(rdst[15:0], ptr);
      `LMX_OP_MOV_B: chk(rdst[7:0], src[7:0]);
      `LMX_OP_MOV_W: chk(rdst[15:0], src[15:0]);
      `LMX_OP_MOV_D: chk(rdst, src);
      `LMX_OP_AND: chk(rdst, dst & src);
      `LMX_OP_OR: chk(rdst, dst | src);
      `LMX_OP_XOR: chk(rdst, dst ^ src);
      default: ;
    endcase
    if (op >= `LMX_OP_AND) chk(rsrc, src);
    k = 1;
    while (done !== 1'b1 && k < 20) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    chk(k, es);
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up;
    end
  end

  initial begin
    sp_m = 16'h0000;
    void'($urandom(71226));
    for (int m = 0; m < 2; m++) begin
      @(posedge sys_clk);
      srst <= 1'b1;
      nat <= m[0];
      sp_in <= $urandom;
      repeat (10) @(posedge sys_clk);
      srst <= 1'b0;
      xd_m = `LMX_XDPL_RST;
      @(posedge sys_clk);
      #1;
      sp_m = sp_in;
      chk({natq, xdpl, spq}, {nat, 8'h01, sp_in});
      for (int op = 1; op <= 28; op++) run(5'(op), `LMX_PEN_NONE, 8'h10);
      run(`LMX_OP_AND, `LMX_PEN_TWO, 8'h80);
      run(`LMX_OP_OR, `LMX_PEN_TWO, 8'h7F);
      run(`LMX_OP_XOR, `LMX_PEN_TWO, 8'h83);
      run(`LMX_OP_MOV_B, `LMX_PEN_ONE, 8'h83);
      run(`LMX_OP_MOV_B, `LMX_PEN_ONE, 8'h84);
      @(posedge sys_clk);
      {xd_we, xd_wr} <= {1'b1, 8'h5A};
      @(posedge sys_clk);
      xd_we <= 1'b0;
      xd_m = 8'h5A;
      #1;
      chk(xdpl, 8'h5A);
      run(`LMX_OP_EXT_RD8, `LMX_PEN_NONE, 8'h3C);
      run(`LMX_OP_EXT_RD16, `LMX_PEN_NONE, 8'h3C);
      repeat (25) begin
        rop = 5'(1 + $urandom % 28);
        // Penalty class only on ops that can name a direct port operand
        pen_r = (rop == `LMX_OP_MOV_B || rop >= `LMX_OP_AND) ? 2'($urandom % 3) : `LMX_PEN_NONE;
        run(rop, pen_r, 8'($urandom));
      end
      $display("test mode %0d done, errors %0d", m, n_errors);
    end
    wrap_up;
  end
endmodule
`default_nettype wire
